// ===== core/adcdg_defines.svh
// constants for the converter diagnostic register bank
// assumes byte-wide registers reached by an 8-bit address
`ifndef ADCDG_DEFINES_SVH
`define ADCDG_DEFINES_SVH

// register offsets
`define ADCDG_OFF_CUSTOM_HI   8'h0E
`define ADCDG_OFF_CUSTOM_LO   8'h0F
`define ADCDG_OFF_STATUS      8'h10
`define ADCDG_OFF_TEMP_UPPER  8'h11
`define ADCDG_OFF_DIAG_CTRL   8'h13
`define ADCDG_OFF_THERMAL     8'h14

// widths
`define ADCDG_DATA_W          8
`define ADCDG_ADDR_W          8
`define ADCDG_WORD_W          12
`define ADCDG_TEMP_W          9

// diagnostic control field positions
`define ADCDG_BIT_REF_CHECK   6
`define ADCDG_BIT_DC_ON       5
`define ADCDG_BIT_STATS_ON    4
`define ADCDG_LS_HI           1
`define ADCDG_LS_LO           0

// thermal readout enable position
`define ADCDG_BIT_THERMAL     2

// custom word low nibble position in its register
`define ADCDG_CLO_HI          7
`define ADCDG_CLO_LO          4

// custom pattern selector codes
`define ADCDG_SEL_CUSTOM_AB   4'h5
`define ADCDG_SEL_CUSTOM_CD   4'h6

// reset values
`define ADCDG_RST_BYTE        8'h00
`define ADCDG_RST_WORD        12'h000

`endif

// ===== core/adcdg_pkg.sv
// types shared by the converter diagnostic register bank
// assumes adcdg_defines.svh sits on the include path
`include "adcdg_defines.svh"

package adcdg_pkg;

   // per-channel reference health flags
   typedef struct packed {
      logic d;                          // channel d healthy flag
      logic c;                          // channel c healthy flag
      logic b;                          // channel b healthy flag
      logic a;                          // channel a healthy flag
   } adcdg_health_s;

   // per-channel test-pattern selectors
   typedef struct packed {
      logic [3:0] d;                    // channel d selector
      logic [3:0] c;                    // channel c selector
      logic [3:0] b;                    // channel b selector
      logic [3:0] a;                    // channel a selector
   } adcdg_sel_s;

   // control bits driven out to the converter core
   typedef struct packed {
      logic       ref_check;            // reference check enabled
      logic       dc_injection_on;      // dc injection enabled
      logic       statistics_on;        // mean/variance module on
      logic       thermal_readout_on;   // temperature code readable
      logic [1:0] low_speed;            // low-speed setting
   } adcdg_ctrl_s;

   // four 12-bit channel words, index 0 is channel a
   typedef logic [3:0][`ADCDG_WORD_W-1:0] adcdg_quad_t;

endpackage

// ===== core/adcdg_sync.sv
// two-flop synchroniser for a group of level inputs
// assumes the levels change slowly against the system clock
`timescale 1ns/1ps
`include "adcdg_defines.svh"

module adcdg_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   logic [W-1:0] meta_reg;              // first stage, read only by dout

   // two stages, frozen while ce is low
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg <= '0;
         dout     <= '0;
      end else if (ce) begin
         meta_reg <= din;
         dout     <= meta_reg;
      end
   end

endmodule

// ===== core/adcdg_pattern.sv
// output word selection for one converter channel
// assumes selector and data come from logic on the same clock
`timescale 1ns/1ps
`include "adcdg_defines.svh"

module adcdg_pattern #(
   parameter logic [3:0] CUSTOM_CODE = `ADCDG_SEL_CUSTOM_AB
) (
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic                     ce,
   input  wire logic [3:0]               sel,
   input  wire logic [`ADCDG_WORD_W-1:0] custom_word,
   input  wire logic [`ADCDG_WORD_W-1:0] conv_data,
   output logic      [`ADCDG_WORD_W-1:0] data_out
);

   wire pick_custom;                    // custom pattern chosen
   wire [`ADCDG_WORD_W-1:0] data_next;  // selected word

   assign pick_custom = (sel == CUSTOM_CODE);
   assign data_next   = pick_custom ? custom_word : conv_data;

   // registered channel word
   always_ff @(posedge clk) begin
      if (rst) begin
         data_out <= `ADCDG_RST_WORD;
      end else if (ce) begin
         data_out <= data_next;
      end
   end

endmodule

// ===== core/adcdg_regs.sv
// converter diagnostic register bank: custom word, health and
// temperature status, diagnostic control, low-speed setting
// assumes a plain register port on CLK_SYS; health, clock and
// temperature inputs arrive from the analog side unsynchronised
//
// What this block does
// [R1] 0x0e holds custom word bits 11-4
// [R2] 0x0f bits 7-4 hold word bits 3-0
// [R3] custom selector code outputs custom word
// [R4] status bits 7,6,5,0 show health b,d,a,c
// [R5] same bits show temperature bits 2,1,0,3
// [R6] temperature bits 6-4 at status bits 3-1
// [R7] temperature bits 8-7 at 0x11 bits 5-4
// [R8] temperature value is two's complement
// [R9] temperature placed only while readout enabled
// [R10] status bit 4 is one when clock absent
// [R11] software enables reference check before reading health
// [R12] 0x13 bit 5 enables dc injection
// [R13] 0x13 bit 4 enables statistics module
// [R14] 0x13 bits 1-0 set low-speed operation
// [R15] software picks low-speed code from sample rate
// [R16] software writes zero to reserved bits
// [R17] all writable fields reset to zero
`timescale 1ns/1ps
`include "adcdg_defines.svh"

module adcdg_regs (
   input  wire logic                      CLK_SYS,
   input  wire logic                      RST,
   input  wire logic                      CE,
   input  wire logic [`ADCDG_ADDR_W-1:0]  ADDR,
   input  wire logic [`ADCDG_DATA_W-1:0]  WDATA,
   input  wire logic                      WR,
   input  wire logic                      RD,
   output logic      [`ADCDG_DATA_W-1:0]  RDATA,
   input  wire adcdg_pkg::adcdg_health_s  REF_HEALTH,
   input  wire logic                      CLK_MISSING,
   input  wire logic [`ADCDG_TEMP_W-1:0]  TEMP_CODE,
   input  wire adcdg_pkg::adcdg_sel_s     PATTERN_SEL,
   input  wire adcdg_pkg::adcdg_quad_t    CONV_DATA,
   input  wire logic [2:0]                DC_LEVEL,
   input  wire logic [1:0]                STATS_PICK,
   output adcdg_pkg::adcdg_quad_t         CH_DATA,
   output logic      [`ADCDG_WORD_W-1:0]  CUSTOM_WORD,
   output adcdg_pkg::adcdg_ctrl_s         CTRL,
   output logic      [2:0]                DC_INJ_LEVEL,
   output logic      [1:0]                STATS_CHANNEL
);

   // ---- synchronised analog-side inputs
   adcdg_pkg::adcdg_health_s       health_s;    // health after sync
   logic                           clk_miss_s;  // clock flag after sync
   logic [`ADCDG_TEMP_W-1:0]       temp_s;      // temperature after sync

   adcdg_sync #(.W(4)) u_sync_health (
      .clk  (CLK_SYS),
      .rst  (RST),
      .ce   (CE),
      .din  (REF_HEALTH),
      .dout (health_s)
   );

   adcdg_sync #(.W(1)) u_sync_clk (
      .clk  (CLK_SYS),
      .rst  (RST),
      .ce   (CE),
      .din  (CLK_MISSING),
      .dout (clk_miss_s)
   );

   // temperature code is two's complement and passes unchanged
   adcdg_sync #(.W(`ADCDG_TEMP_W)) u_sync_temp (
      .clk  (CLK_SYS),
      .rst  (RST),
      .ce   (CE),
      .din  (TEMP_CODE),                        // R8
      .dout (temp_s)
   );

   // ---- stored registers
   logic [`ADCDG_WORD_W-1:0] custom_reg;        // shared custom word
   logic                     ref_check_reg;     // reference check on
   logic                     dc_on_reg;         // dc injection on
   logic                     stats_on_reg;      // statistics on
   logic [1:0]               low_speed_reg;     // low-speed code
   logic                     thermal_reg;       // temperature readout on

   // ---- address decode
   wire hit_chi;                                // custom high selected
   wire hit_clo;                                // custom low selected
   wire hit_stat;                               // status selected
   wire hit_tup;                                // temperature upper
   wire hit_diag;                               // diagnostic control
   wire hit_therm;                              // thermal control
   wire wr_go;                                  // write taken this cycle
   wire rd_go;                                  // read taken this cycle

   assign hit_chi   = (ADDR == `ADCDG_OFF_CUSTOM_HI);
   assign hit_clo   = (ADDR == `ADCDG_OFF_CUSTOM_LO);
   assign hit_stat  = (ADDR == `ADCDG_OFF_STATUS);
   assign hit_tup   = (ADDR == `ADCDG_OFF_TEMP_UPPER);
   assign hit_diag  = (ADDR == `ADCDG_OFF_DIAG_CTRL);
   assign hit_therm = (ADDR == `ADCDG_OFF_THERMAL);
   assign wr_go     = CE & WR;
   assign rd_go     = CE & RD;

   // ---- next values of the writable fields
   logic [`ADCDG_WORD_W-1:0] custom_next;       // custom word next
   logic                     ref_check_next;    // reference check next
   logic                     dc_on_next;        // dc injection next
   logic                     stats_on_next;     // statistics next
   logic [1:0]               low_speed_next;    // low-speed next
   logic                     thermal_next;      // readout enable next

   // write decode; reserved write-only bits are simply dropped
   always_comb begin
      custom_next    = custom_reg;
      ref_check_next = ref_check_reg;
      dc_on_next     = dc_on_reg;
      stats_on_next  = stats_on_reg;
      low_speed_next = low_speed_reg;
      thermal_next   = thermal_reg;
      if (wr_go && hit_chi) begin
         custom_next[`ADCDG_WORD_W-1:4] = WDATA;                  // R1
      end
      if (wr_go && hit_clo) begin
         custom_next[3:0] = WDATA[`ADCDG_CLO_HI:`ADCDG_CLO_LO];    // R2
      end
      if (wr_go && hit_diag) begin
         ref_check_next = WDATA[`ADCDG_BIT_REF_CHECK];
         dc_on_next     = WDATA[`ADCDG_BIT_DC_ON];                 // R12
         stats_on_next  = WDATA[`ADCDG_BIT_STATS_ON];              // R13
         low_speed_next = WDATA[`ADCDG_LS_HI:`ADCDG_LS_LO];        // R14
      end
      if (wr_go && hit_therm) begin
         thermal_next = WDATA[`ADCDG_BIT_THERMAL];
      end
   end

   // writable fields, all zero after reset
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         custom_reg    <= `ADCDG_RST_WORD;                          // R17
         ref_check_reg <= 1'b0;
         dc_on_reg     <= 1'b0;
         stats_on_reg  <= 1'b0;
         low_speed_reg <= 2'h0;
         thermal_reg   <= 1'b0;
      end else if (CE) begin
         custom_reg    <= custom_next;
         ref_check_reg <= ref_check_next;
         dc_on_reg     <= dc_on_next;
         stats_on_reg  <= stats_on_next;
         low_speed_reg <= low_speed_next;
         thermal_reg   <= thermal_next;
      end
   end

   // ---- status composition
   logic [`ADCDG_DATA_W-1:0] status_byte;       // status register view
   logic [`ADCDG_DATA_W-1:0] tup_byte;          // temperature upper view

   // temperature wins the shared bits; health needs the check on
   always_comb begin
      status_byte    = `ADCDG_RST_BYTE;
      status_byte[4] = clk_miss_s;                                 // R10
      if (thermal_reg) begin
         status_byte[7:5] = {temp_s[2], temp_s[1], temp_s[0]};     // R5
         status_byte[3:1] = temp_s[6:4];                           // R6
         status_byte[0]   = temp_s[3];                             // R5
      end else if (ref_check_reg) begin
         status_byte[7] = health_s.b;                              // R4
         status_byte[6] = health_s.d;                              // R4
         status_byte[5] = health_s.a;                              // R4
         status_byte[0] = health_s.c;                              // R4
      end
   end

   // upper temperature bits only while readout is on
   always_comb begin
      tup_byte = `ADCDG_RST_BYTE;
      if (thermal_reg) begin
         tup_byte[5:4] = temp_s[8:7];                              // R7 R9
      end
   end

   // ---- read mux; unmapped and write-only bits read zero
   wire [`ADCDG_DATA_W-1:0] diag_byte;          // diagnostic readback
   wire [`ADCDG_DATA_W-1:0] therm_byte;         // thermal readback
   wire [`ADCDG_DATA_W-1:0] clo_byte;           // custom low readback
   logic [`ADCDG_DATA_W-1:0] rd_next;           // read data next

   assign diag_byte  = {1'b0, ref_check_reg, dc_on_reg, stats_on_reg,
                        2'h0, low_speed_reg};
   assign therm_byte = {5'h00, thermal_reg, 2'h0};
   assign clo_byte   = {custom_reg[3:0], 4'h0};

   // pick the addressed byte on a read, else zero
   always_comb begin
      rd_next = `ADCDG_RST_BYTE;
      if (rd_go) begin
         case (1'b1)
            hit_chi:   rd_next = custom_reg[`ADCDG_WORD_W-1:4];
            hit_clo:   rd_next = clo_byte;
            hit_stat:  rd_next = status_byte;
            hit_tup:   rd_next = tup_byte;
            hit_diag:  rd_next = diag_byte;
            hit_therm: rd_next = therm_byte;
            default:   rd_next = `ADCDG_RST_BYTE;
         endcase
      end
   end

   // read data, present only in the cycle after the strobe
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         RDATA <= `ADCDG_RST_BYTE;
      end else if (CE) begin
         RDATA <= rd_next;
      end
   end

   // ---- control outputs, dependent fields gated by their enable
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         CUSTOM_WORD   <= `ADCDG_RST_WORD;
         CTRL          <= '0;
         DC_INJ_LEVEL  <= 3'h0;
         STATS_CHANNEL <= 2'h0;
      end else if (CE) begin
         CUSTOM_WORD   <= custom_reg;
         CTRL          <= {ref_check_reg, dc_on_reg, stats_on_reg,
                           thermal_reg, low_speed_reg};            // R14
         DC_INJ_LEVEL  <= dc_on_reg ? DC_LEVEL : 3'h0;             // R12
         STATS_CHANNEL <= stats_on_reg ? STATS_PICK : 2'h0;        // R13
      end
   end

   // ---- channel output words
   adcdg_pattern #(.CUSTOM_CODE(`ADCDG_SEL_CUSTOM_AB)) u_pat_a (
      .clk         (CLK_SYS),
      .rst         (RST),
      .ce          (CE),
      .sel         (PATTERN_SEL.a),                                // R3
      .custom_word (custom_reg),
      .conv_data   (CONV_DATA[0]),
      .data_out    (CH_DATA[0])
   );

   adcdg_pattern #(.CUSTOM_CODE(`ADCDG_SEL_CUSTOM_AB)) u_pat_b (
      .clk         (CLK_SYS),
      .rst         (RST),
      .ce          (CE),
      .sel         (PATTERN_SEL.b),                                // R3
      .custom_word (custom_reg),
      .conv_data   (CONV_DATA[1]),
      .data_out    (CH_DATA[1])
   );

   adcdg_pattern #(.CUSTOM_CODE(`ADCDG_SEL_CUSTOM_CD)) u_pat_c (
      .clk         (CLK_SYS),
      .rst         (RST),
      .ce          (CE),
      .sel         (PATTERN_SEL.c),                                // R3
      .custom_word (custom_reg),
      .conv_data   (CONV_DATA[2]),
      .data_out    (CH_DATA[2])
   );

   adcdg_pattern #(.CUSTOM_CODE(`ADCDG_SEL_CUSTOM_CD)) u_pat_d (
      .clk         (CLK_SYS),
      .rst         (RST),
      .ce          (CE),
      .sel         (PATTERN_SEL.d),                                // R3
      .custom_word (custom_reg),
      .conv_data   (CONV_DATA[3]),
      .data_out    (CH_DATA[3])
   );

   // ---- assertions
   a_custom_high_write: assert property ( // R1
      @(posedge CLK_SYS) disable iff (RST)
      (wr_go && hit_chi) |=> (custom_reg[11:4] == $past(WDATA))
   ) else $error("custom high byte not stored");
   a_custom_low_write: assert property ( // R2
      @(posedge CLK_SYS) disable iff (RST)
      (wr_go && hit_clo) |=> (custom_reg[3:0] == $past(WDATA[7:4]))
         ##1 (!$past(CE) || CUSTOM_WORD[3:0] == $past(custom_reg[3:0]))
   ) else $error("custom low nibble not stored or not driven");
   a_custom_on_chan: assert property ( // R3
      @(posedge CLK_SYS) disable iff (RST)
      (CE && PATTERN_SEL.c == `ADCDG_SEL_CUSTOM_CD)
         |=> (CH_DATA[2] == $past(custom_reg))
   ) else $error("channel c does not show the custom word");
   a_health_read: assert property ( // R4
      @(posedge CLK_SYS) disable iff (RST)
      (rd_go && hit_stat && ref_check_reg && !thermal_reg)
         |=> (RDATA[7] == $past(health_s.b)
              && RDATA[6] == $past(health_s.d)
              && RDATA[5] == $past(health_s.a)
              && RDATA[0] == $past(health_s.c))
   ) else $error("health flags misplaced in status");
   a_temp_status_read: assert property ( // R6
      @(posedge CLK_SYS) disable iff (RST)
      (rd_go && hit_stat && thermal_reg)
         |=> (RDATA[7:5] == $past(temp_s[2:0])
              && RDATA[3:1] == $past(temp_s[6:4])
              && RDATA[0] == $past(temp_s[3]))
   ) else $error("temperature bits misplaced in status");
   a_temp_upper_gate: assert property ( // R9
      @(posedge CLK_SYS) disable iff (RST)
      (rd_go && hit_tup)
         |=> (RDATA[5:4] == ($past(thermal_reg) ? $past(temp_s[8:7])
                                                : 2'h0))
   ) else $error("upper temperature bits wrong");
   a_clock_flag_read: assert property ( // R10
      @(posedge CLK_SYS) disable iff (RST)
      (rd_go && hit_stat) |=> (RDATA[4] == $past(clk_miss_s))
   ) else $error("clock flag not reported");
   a_dc_level_gate: assert property ( // R12
      @(posedge CLK_SYS) disable iff (RST)
      (DC_INJ_LEVEL != 3'h0) |-> CTRL.dc_injection_on
   ) else $error("dc level driven while injection off");
   a_stats_pick_gate: assert property ( // R13
      @(posedge CLK_SYS) disable iff (RST)
      (CE && !stats_on_reg) |=> (STATS_CHANNEL == 2'h0)
   ) else $error("statistics channel driven while off");
   a_low_speed_path: assert property ( // R14
      @(posedge CLK_SYS) disable iff (RST)
      (wr_go && hit_diag) ##1 CE
         |=> (CTRL.low_speed == $past(WDATA[1:0], 2))
   ) else $error("low-speed code not passed out");
   a_reset_clears: assert property ( // R17
      @(posedge CLK_SYS)
      $fell(RST) |-> (custom_reg == 12'h000 && CTRL == '0
                      && RDATA == 8'h00)
   ) else $error("fields not zero after reset");

endmodule

// ===== verification/adcdg_regs_tb.sv
// self-checking bench for the converter diagnostic register bank
// assumes adcdg_pkg is compiled first and the defines header is on
// the include path; design assertions live in the design files
`timescale 1ns/1ps
`include "adcdg_defines.svh"

module adcdg_regs_tb;

   logic                         clk_sys;      // system clock
   logic                         rst;          // sync reset
   logic                         ce;           // clock enable
   logic [7:0]                   addr;         // register address
   logic [7:0]                   wdata;        // write data
   logic                         wr;           // write strobe
   logic                         rd_s;         // read strobe
   logic [7:0]                   rdata;        // read data
   adcdg_pkg::adcdg_health_s     health;       // reference flags
   logic                         clk_missing;  // clock absent flag
   logic [8:0]                   temp;         // temperature code
   adcdg_pkg::adcdg_sel_s        psel;         // pattern selectors
   adcdg_pkg::adcdg_quad_t       conv;         // conversion words
   logic [2:0]                   dc_level;     // requested dc level
   logic [1:0]                   stats_pick;   // requested stats channel
   adcdg_pkg::adcdg_quad_t       ch_data;      // channel outputs
   logic [11:0]                  custom_word;  // custom word copy
   adcdg_pkg::adcdg_ctrl_s       ctrl;         // control outputs
   logic [2:0]                   dc_inj;       // gated dc level
   logic [1:0]                   stats_ch;     // gated stats channel
   int                           miscompares;  // mismatch count
   int                           checks;       // comparison count
   integer                       seed = 32'hEDBD; // fixed seed
   logic [7:0]                   hi;           // custom word high byte
   logic [7:0]                   lo;           // custom word low byte
   logic [7:0]                   d;            // diag control value
   logic                         th;           // readout enable

   adcdg_regs u_adcdg_regs (
      .CLK_SYS       (clk_sys),
      .RST           (rst),
      .CE            (ce),
      .ADDR          (addr),
      .WDATA         (wdata),
      .WR            (wr),
      .RD            (rd_s),
      .RDATA         (rdata),
      .REF_HEALTH    (health),
      .CLK_MISSING   (clk_missing),
      .TEMP_CODE     (temp),
      .PATTERN_SEL   (psel),
      .CONV_DATA     (conv),
      .DC_LEVEL      (dc_level),
      .STATS_PICK    (stats_pick),
      .CH_DATA       (ch_data),
      .CUSTOM_WORD   (custom_word),
      .CTRL          (ctrl),
      .DC_INJ_LEVEL  (dc_inj),
      .STATS_CHANNEL (stats_ch)
   );

   // free-running 125 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // status byte as software should see it
   function automatic logic [7:0] exp_status(
      input adcdg_pkg::adcdg_health_s h, input logic cm,
      input logic [8:0] t, input logic rc, input logic tr);
      logic [7:0] s;
      s = 8'h00;
      s[4] = cm;
      if (tr) begin
         s = {t[2], t[1], t[0], cm, t[6:4], t[3]};
      end else if (rc) begin
         s = {h.b, h.d, h.a, cm, 3'h0, h.c};
      end
      return s;
   endfunction

   // register read-back comparison
   task automatic chk_reg(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h got %h", nm, e, g);
      end
   endtask

   // output port comparison
   task automatic chk_out(input string nm, input logic [11:0] e,
                          input logic [11:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h got %h", nm, e, g);
      end
   endtask

   // one-cycle write strobe
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask

   // one-cycle read strobe, data sampled in the following cycle
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e,
                         input string nm);
      @(posedge clk_sys);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_sys);
      rd_s <= 1'b0;
      #1;
      chk_reg(nm, e, rdata);
   endtask

   // verdict and end of run
   task automatic end_sim;
      if (miscompares == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // hang guard, far beyond the expected run length
   initial begin
      #200000;
      miscompares++;
      end_sim;
   end

   // main sequence
   initial begin
      rst = 1'b1; ce = 1'b1; addr = 8'h00; wdata = 8'h00; wr = 1'b0;
      rd_s = 1'b0; health = 4'h0; clk_missing = 1'b0; temp = 9'h000;
      psel = 16'h0000; conv = 48'h0; dc_level = 3'h0; stats_pick = 2'h0;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      // custom, status and diagnostic control registers read zero after reset
      rd_reg(`ADCDG_OFF_CUSTOM_HI, 8'h00, "reset hi");
      rd_reg(`ADCDG_OFF_CUSTOM_LO, 8'h00, "reset lo");
      rd_reg(`ADCDG_OFF_STATUS, 8'h00, "reset status");
      rd_reg(`ADCDG_OFF_DIAG_CTRL, 8'h00, "reset diag");
      chk_out("reset ctrl", 12'h000, 12'(ctrl));
      // custom word bytes, then custom and swapped selector codes
      for (int i = 0; i < 6; i++) begin
         hi = (i == 0) ? 8'hFF : 8'($random(seed));
         lo = (i == 0) ? 8'hFF : 8'($random(seed));
         wr_reg(`ADCDG_OFF_CUSTOM_HI, hi);
         wr_reg(`ADCDG_OFF_CUSTOM_LO, lo);
         rd_reg(`ADCDG_OFF_CUSTOM_HI, hi, "custom hi");
         rd_reg(`ADCDG_OFF_CUSTOM_LO, {lo[7:4], 4'h0}, "custom lo");
         chk_out("custom word", {hi, lo[7:4]}, custom_word);
         @(posedge clk_sys);
         psel <= (i % 2 == 0) ? 16'h6655 : 16'h5566;
         conv <= {16'($random(seed)), 32'($random(seed))};
         repeat (2) @(posedge clk_sys);
         #1;
         for (int k = 0; k < 4; k++) begin
            chk_out("channel word", (i % 2 == 0) ? {hi, lo[7:4]}
                    : conv[k], ch_data[k]);
         end
      end
      // writes with the clock enable low are ignored
      @(posedge clk_sys);
      ce <= 1'b0;
      wr_reg(`ADCDG_OFF_CUSTOM_HI, ~hi);
      ce <= 1'b1;
      rd_reg(`ADCDG_OFF_CUSTOM_HI, hi, "frozen hi");
      // diagnostic control, status mux and temperature readout
      for (int i = 0; i < 12; i++) begin
         d = 8'($random(seed));
         d[1:0] = i[1] ? {1'b1, i[0]} : 2'h0;
         th = i[2];
         wr_reg(`ADCDG_OFF_DIAG_CTRL, d & 8'h73);
         wr_reg(`ADCDG_OFF_THERMAL, {5'h00, th, 2'h0});
         @(posedge clk_sys);
         health <= 4'($random(seed));
         clk_missing <= 1'($random(seed));
         temp <= (i == 4) ? 9'h100 : (i == 5) ? 9'h0FF : 9'($random(seed));
         dc_level <= 3'($random(seed));
         stats_pick <= 2'($random(seed));
         repeat (4) @(posedge clk_sys);
         rd_reg(`ADCDG_OFF_DIAG_CTRL, d & 8'h73, "diag ctrl");
         rd_reg(`ADCDG_OFF_STATUS, exp_status(health, clk_missing, temp,
                d[6], th), "status");
         rd_reg(`ADCDG_OFF_TEMP_UPPER, th ? {2'h0, temp[8:7], 4'h0}
                : 8'h00, "temp upper");
         chk_out("ctrl", 12'({d[6], d[5], d[4], th, d[1:0]}),
                 12'(ctrl));
         chk_out("dc level", 12'(d[5] ? dc_level : 3'h0),
                 12'(dc_inj));
         chk_out("stats channel", 12'(d[4] ? stats_pick : 2'h0),
                 12'(stats_ch));
      end
      // unmapped address reads zero, and read data falls back
      wr_reg(8'h12, 8'hFF);
      rd_reg(8'h12, 8'h00, "unmapped");
      @(posedge clk_sys);
      #1;
      chk_reg("rdata idle", 8'h00, rdata);
      wr_reg(`ADCDG_OFF_THERMAL, 8'h04);
      // second reset in mid-run clears every writable field
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      rd_reg(`ADCDG_OFF_CUSTOM_HI, 8'h00, "rerun hi");
      rd_reg(`ADCDG_OFF_THERMAL, 8'h00, "rerun thermal");
      rd_reg(`ADCDG_OFF_TEMP_UPPER, 8'h00, "rerun upper");
      chk_out("rerun ctrl", 12'h000, 12'(ctrl));
      end_sim;
   end

endmodule
